// ==== cpt_top.sv ====
/*
 * Capture units, output control, output events and interrupt flags of a 12-bit
 * control PWM timer. Assumes the counter, its phase and input events come from
 * timer logic on a foreign clock (synchronised here) and a classic Wishbone master.
 */
`timescale 1ns/10ps
module cpt_top
    import cpt_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire logic ce_i,
    input wire logic [7:0] fuse_cfg_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Timer core, foreign domain
    input wire logic [11:0] count_i,
    input wire logic [1:0] phase_i,
    input wire logic one_ramp_i,
    input wire logic cycle_end_i,
    input wire logic fault_i,
    input wire logic [1:0] core_wave_i,
    // Event inputs
    input wire logic event_a_i,
    input wire logic event_b_i,
    // Input mode actions toward the counter
    output logic input_act_a_o,
    output logic input_act_b_o,
    // Waveform outputs
    output logic waveform_out_a_o,
    output logic waveform_out_b_o,
    output logic waveform_out_c_o,
    output logic waveform_out_d_o,
    output logic [3:0] waveform_oe_o,
    // Output events
    output logic ev_b_clear_o,
    output logic ev_a_set_o,
    output logic ev_b_set_o,
    output logic ev_prog_o,
    // Interrupt requests
    output logic irq_ovf_o,
    output logic irq_on_time_entry_interrupt_o
);
    // Phase encoding of phase_i: dead A, on A, dead B, on B
    localparam logic [1:0] PH_ON_A = 2'h1;
    localparam logic [1:0] PH_ON_B = 2'h3;

    typedef struct packed {
        logic [1:0][11:0] cnt_s1;
        logic [1:0][11:0] cnt_s2;
        logic [10:0] in_s1;
        logic [10:0] in_s2;
        logic [10:0] in_prev;
        logic [1:0][11:0] snap;
        logic [1:0] busy;
        logic [7:0] ctrl_c;
        logic [7:0] ctrl_d;
        logic [1:0][7:0] event_input_control;
        logic [7:0] int_en;
        logic [7:0] int_flag;
        logic [7:0] fault;
        logic [7:0] dly_ctrl;
        logic [7:0] dly_val;
        logic [2:0][11:0] cmp;
        logic [3:0] wave;
        logic [3:0] oe;
        logic [3:0] cmp_ev;
        logic [1:0] act;
        logic fault_hold;
        logic [31:0] rdata;
        logic ack;
        logic irq_ovf;
        logic irq_on_time_entry_interrupt;
    } cpt_s;
    cpt_s s_q, s_d;

    logic [10:0] in_raw;
    logic [11:0] cnt_now;
    logic [1:0] ev_rise;
    logic ovf_ev, ona_ev, onb_ev, wr, rd;
    logic [1:0] sw_strobe, on_time_entry_interrupt, take;
    logic dly_on_time_entry_interrupt, dly_delayed;

    // Word decode shared by read and write paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_adr);
        hit = (a == reg_adr);
    endfunction : hit

    function automatic logic ov_level(input logic [3:0] val, input logic [1:0] ph);
        ov_level = val[ph];
    endfunction : ov_level

    assign in_raw = {core_wave_i, fault_i, phase_i, cycle_end_i, event_b_i, event_a_i,
                     one_ramp_i, 2'h0};

    cpt_delay u_delay (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .delayed_i(dly_delayed),
        .presc_i(s_q.dly_ctrl[DLY_PRESC_LSB +: 2]),
        .dly_val_i(s_q.dly_val),
        .on_time_entry_interrupt_i(dly_on_time_entry_interrupt),
        .event_o(ev_prog_o)
    );

    always_comb begin
        s_d = s_q;
        // Both stages of the synchroniser for pins from the timer domain
        s_d.in_s1 = in_raw;
        s_d.in_s2 = s_q.in_s1;
        s_d.in_prev = s_q.in_s2;
        s_d.cnt_s1 = {count_i, count_i};
        // Upper copy keeps the previous synchronised value for match-entry detection
        s_d.cnt_s2[0] = s_q.cnt_s1[0];
        s_d.cnt_s2[1] = s_q.cnt_s2[0];
        // Counter values taken only after two stages; a moving counter may skew by one
        cnt_now = s_q.cnt_s2[0];
        ev_rise = s_q.in_s2[4:3] & ~s_q.in_prev[4:3];
        ovf_ev = s_q.in_s2[5] & ~s_q.in_prev[5];
        ona_ev = (s_q.in_s2[7:6] == PH_ON_A) && (s_q.in_prev[7:6] != PH_ON_A);
        onb_ev = (s_q.in_s2[7:6] == PH_ON_B) && (s_q.in_prev[7:6] != PH_ON_B);
        wr = cyc_i & stb_i & we_i & ~s_q.ack & sel_i[0];
        rd = cyc_i & stb_i & ~we_i & ~s_q.ack;
        sw_strobe[0] = wr & hit(adr_i, ADDR_CTRL_E) & dat_i[CONTROL_REGISTER_E_SWA_BIT];
        sw_strobe[1] = wr & hit(adr_i, ADDR_CTRL_E) & dat_i[CONTROL_REGISTER_E_SWB_BIT];
        for (int i = 0; i < 2; i++) begin
            // Event drives the input mode and the capture from one edge
            s_d.act[i] = ev_rise[i] & s_q.event_input_control[i][EVENT_INPUT_CONTROL_ENABLE_BIT];
            on_time_entry_interrupt[i] = sw_strobe[i] | (s_d.act[i] & s_q.event_input_control[i][EVENT_INPUT_CONTROL_ACTION_BIT]);
            take[i] = on_time_entry_interrupt[i] & ~s_q.busy[i];
            if (take[i]) begin
                s_d.snap[i] = cnt_now;
                s_d.busy[i] = 1'b1;
            end
        end
        // Compare match strobes, one cycle each
        s_d.cmp_ev[0] = (cnt_now == s_q.cmp[0]) && (s_q.cnt_s2[1] != s_q.cmp[0]);
        s_d.cmp_ev[1] = (cnt_now == s_q.cmp[1]) && (s_q.cnt_s2[1] != s_q.cmp[1])
                        && s_q.cmp_ev[3];
        s_d.cmp_ev[2] = (cnt_now == s_q.cmp[2]) && (s_q.cnt_s2[1] != s_q.cmp[2])
                        && s_q.cmp_ev[3];
        s_d.cmp_ev[3] = !(s_d.cmp_ev[0]);
        // Wishbone single-cycle ack; reads answer next edge
        s_d.ack = cyc_i & stb_i & ~s_q.ack;
        s_d.rdata = 32'h0000_0000;
        if (rd) begin
            case (adr_i)
                ADDR_CTRL_C: s_d.rdata[7:0] = s_q.ctrl_c;
                ADDR_CTRL_D: s_d.rdata[7:0] = s_q.ctrl_d;
                ADDR_EVENT_INPUT_CONTROL_A: s_d.rdata[7:0] = s_q.event_input_control[0];
                ADDR_EVENT_INPUT_CONTROL_B: s_d.rdata[7:0] = s_q.event_input_control[1];
                ADDR_INT_EN: s_d.rdata[7:0] = s_q.int_en;
                ADDR_INT_FLAG: s_d.rdata[7:0] = s_q.int_flag;
                ADDR_STATUS: s_d.rdata[STATUS_COMMAND_READY_FLAG_BIT] = ~|s_q.busy;
                ADDR_FAULT_CTRL: s_d.rdata[7:0] = s_q.fault;
                ADDR_DLY_CTRL: s_d.rdata[7:0] = s_q.dly_ctrl;
                ADDR_DLY_VAL: s_d.rdata[7:0] = s_q.dly_val;
                ADDR_SNAP_A_LO: s_d.rdata[7:0] = s_q.snap[0][7:0];
                ADDR_SNAP_A_HI: s_d.rdata[3:0] = s_q.snap[0][11:8];
                ADDR_SNAP_B_LO: s_d.rdata[7:0] = s_q.snap[1][7:0];
                ADDR_SNAP_B_HI: s_d.rdata[3:0] = s_q.snap[1][11:8];
                ADDR_CMP_BCLR: s_d.rdata[11:0] = s_q.cmp[0];
                ADDR_CMP_ASET: s_d.rdata[11:0] = s_q.cmp[1];
                ADDR_CMP_BSET: s_d.rdata[11:0] = s_q.cmp[2];
                default: s_d.rdata = 32'h0000_0000;
            endcase
            if (hit(adr_i, ADDR_SNAP_A_HI) && !take[0]) begin
                s_d.busy[0] = 1'b0;
            end
            if (hit(adr_i, ADDR_SNAP_B_HI) && !take[1]) begin
                s_d.busy[1] = 1'b0;
            end
        end
        if (wr) begin
            case (adr_i)
                ADDR_CTRL_C: s_d.ctrl_c = dat_i[7:0];
                ADDR_CTRL_D: s_d.ctrl_d = dat_i[7:0];
                ADDR_EVENT_INPUT_CONTROL_A: s_d.event_input_control[0] = dat_i[7:0];
                ADDR_EVENT_INPUT_CONTROL_B: s_d.event_input_control[1] = dat_i[7:0];
                ADDR_INT_EN: s_d.int_en = dat_i[7:0];
                ADDR_INT_FLAG: s_d.int_flag = s_q.int_flag & ~dat_i[7:0];
                ADDR_FAULT_CTRL: s_d.fault = dat_i[7:0];
                ADDR_DLY_CTRL: s_d.dly_ctrl = dat_i[7:0];
                ADDR_DLY_VAL: s_d.dly_val = dat_i[7:0];
                ADDR_CMP_BCLR: s_d.cmp[0] = dat_i[11:0];
                ADDR_CMP_ASET: s_d.cmp[1] = dat_i[11:0];
                ADDR_CMP_BSET: s_d.cmp[2] = dat_i[11:0];
                default: s_d.ctrl_c = s_d.ctrl_c;
            endcase
        end
        // Hardware set wins over a same-cycle clear
        if (ovf_ev) begin
            s_d.int_flag[FLAG_OVF_BIT] = 1'b1;
        end
        if (ona_ev || take[0]) begin
            s_d.int_flag[FLAG_ON_TIME_A_ENTRY_FLAG_BIT] = 1'b1;
        end
        if (onb_ev || take[1]) begin
            s_d.int_flag[FLAG_ON_TIME_B_ENTRY_FLAG_BIT] = 1'b1;
        end
        s_d.irq_ovf = s_d.int_flag[FLAG_OVF_BIT] & s_d.int_en[FLAG_OVF_BIT];
        s_d.irq_on_time_entry_interrupt = |(s_d.int_flag[FLAG_ON_TIME_B_ENTRY_FLAG_BIT:FLAG_ON_TIME_A_ENTRY_FLAG_BIT]
                         & s_d.int_en[FLAG_ON_TIME_B_ENTRY_FLAG_BIT:FLAG_ON_TIME_A_ENTRY_FLAG_BIT]);
        // Waveform outputs
        s_d.fault_hold = s_q.in_s2[8];
        if (s_q.in_s2[8]) begin
            s_d.wave = s_q.fault[3:0];
        end else begin
            if (s_q.ctrl_c[CONTROL_REGISTER_C_OVR_BIT]) begin
                // One-ramp override restricts each output to its own phases
                if (s_q.in_s2[2] && s_q.in_s2[7]) begin
                    s_d.wave[0] = s_q.wave[0];
                end else begin
                    s_d.wave[0] = ov_level(s_q.ctrl_d[3:0], s_q.in_s2[7:6]);
                end
                if (s_q.in_s2[2] && !s_q.in_s2[7]) begin
                    s_d.wave[1] = s_q.wave[1];
                end else begin
                    s_d.wave[1] = ov_level(s_q.ctrl_d[7:4], s_q.in_s2[7:6]);
                end
            end else begin
                s_d.wave[1:0] = s_q.in_s2[10:9];
            end
            s_d.wave[2] = s_q.ctrl_c[CONTROL_REGISTER_C_CSEL_BIT] ? s_d.wave[1] : s_d.wave[0];
            s_d.wave[3] = s_q.ctrl_c[CONTROL_REGISTER_C_DSEL_BIT] ? s_d.wave[1] : s_d.wave[0];
        end
        s_d.oe = s_q.fault[7:4];
        // Shared blanking and delay trigger source
        dly_delayed = (s_q.dly_ctrl[DLY_ON_TIME_ENTRY_INTERRUPT_LSB +: 2] == DLY_ON_TIME_ENTRY_INTERRUPT_DELAYED)
                      && (s_q.dly_ctrl[DLY_SEL_LSB +: 2] != DLY_SEL_BLANK);
        case (s_q.dly_ctrl[DLY_ON_TIME_ENTRY_INTERRUPT_LSB +: 2])
            2'h0: dly_on_time_entry_interrupt = s_q.cmp_ev[0];
            2'h1: dly_on_time_entry_interrupt = s_q.cmp_ev[1];
            2'h2: dly_on_time_entry_interrupt = s_q.cmp_ev[2];
            default: dly_on_time_entry_interrupt = ovf_ev;
        endcase
        dly_on_time_entry_interrupt = dly_on_time_entry_interrupt && (s_q.dly_ctrl[DLY_SEL_LSB +: 2] != DLY_SEL_OFF);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || por_i) begin
            s_q <= '0;
            s_q.fault <= por_i ? FAULT_POR_VALUE : fuse_cfg_i;
            s_q.wave <= por_i ? FAULT_POR_VALUE[3:0] : fuse_cfg_i[3:0];
            s_q.cmp_ev[3] <= 1'b1;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign dat_o = s_q.rdata;
    assign ack_o = s_q.ack;
    assign input_act_a_o = s_q.act[0];
    assign input_act_b_o = s_q.act[1];
    assign waveform_out_a_o = s_q.wave[0];
    assign waveform_out_b_o = s_q.wave[1];
    assign waveform_out_c_o = s_q.wave[2];
    assign waveform_out_d_o = s_q.wave[3];
    assign waveform_oe_o = s_q.oe;
    assign ev_b_clear_o = s_q.cmp_ev[0];
    assign ev_a_set_o = s_q.cmp_ev[1];
    assign ev_b_set_o = s_q.cmp_ev[2];
    assign irq_ovf_o = s_q.irq_ovf;
    assign irq_on_time_entry_interrupt_o = s_q.irq_on_time_entry_interrupt;
endmodule : cpt_top

// ==== cpt_pkg.sv ====
/*
 * Constants for the control PWM timer capture, output control and event block.
 * Assumes a 32-bit classic Wishbone slave with byte and 12-bit compare registers in the low bits of each word.
 */
package cpt_pkg;
    // Register byte addresses, one aligned word per register
    localparam logic [7:0] ADDR_CTRL_C = 8'h08;
    localparam logic [7:0] ADDR_CTRL_D = 8'h0C;
    localparam logic [7:0] ADDR_CTRL_E = 8'h10;
    localparam logic [7:0] ADDR_EVENT_INPUT_CONTROL_A = 8'h20;
    localparam logic [7:0] ADDR_EVENT_INPUT_CONTROL_B = 8'h24;
    localparam logic [7:0] ADDR_INT_EN = 8'h30;
    localparam logic [7:0] ADDR_INT_FLAG = 8'h34;
    localparam logic [7:0] ADDR_STATUS = 8'h38;
    localparam logic [7:0] ADDR_FAULT_CTRL = 8'h48;
    localparam logic [7:0] ADDR_DLY_CTRL = 8'h50;
    localparam logic [7:0] ADDR_DLY_VAL = 8'h54;
    localparam logic [7:0] ADDR_SNAP_A_LO = 8'h88;
    localparam logic [7:0] ADDR_SNAP_A_HI = 8'h8C;
    localparam logic [7:0] ADDR_SNAP_B_LO = 8'h90;
    localparam logic [7:0] ADDR_SNAP_B_HI = 8'h94;
    localparam logic [7:0] ADDR_CMP_BCLR = 8'hA0;
    localparam logic [7:0] ADDR_CMP_ASET = 8'hA4;
    localparam logic [7:0] ADDR_CMP_BSET = 8'hA8;
    // Field positions
    localparam int CONTROL_REGISTER_C_OVR_BIT = 0;
    localparam int CONTROL_REGISTER_C_CSEL_BIT = 6;
    localparam int CONTROL_REGISTER_C_DSEL_BIT = 7;
    localparam int CONTROL_REGISTER_E_SWA_BIT = 2;
    localparam int CONTROL_REGISTER_E_SWB_BIT = 3;
    localparam int EVENT_INPUT_CONTROL_ACTION_BIT = 2;
    localparam int EVENT_INPUT_CONTROL_ENABLE_BIT = 0;
    localparam int FLAG_OVF_BIT = 0;
    localparam int FLAG_ON_TIME_A_ENTRY_FLAG_BIT = 2;
    localparam int FLAG_ON_TIME_B_ENTRY_FLAG_BIT = 3;
    localparam int STATUS_COMMAND_READY_FLAG_BIT = 1;
    localparam int DLY_SEL_LSB = 0;
    localparam int DLY_ON_TIME_ENTRY_INTERRUPT_LSB = 2;
    localparam int DLY_PRESC_LSB = 4;
    // Field values
    localparam logic [1:0] DLY_SEL_OFF = 2'h0;
    localparam logic [1:0] DLY_SEL_BLANK = 2'h1;
    localparam logic [1:0] DLY_ON_TIME_ENTRY_INTERRUPT_DELAYED = 2'h2;
    localparam logic [7:0] FAULT_POR_VALUE = 8'h00;
    localparam int CNT_W = 12;
endpackage : cpt_pkg

// ==== cpt_delay.sv ====
/*
 * Programmable delayed output event: prescaled delay clock enable and delay counter.
 * Assumes trigger pulses on the same clock; emits a one-cycle strobe.
 */
`timescale 1ns/10ps
module cpt_delay (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Control
    input wire logic delayed_i,
    input wire logic [1:0] presc_i,
    input wire logic [7:0] dly_val_i,
    input wire logic on_time_entry_interrupt_i,
    // Event
    output logic event_o
);
    typedef enum logic [0:0] {CPT_DLY_IDLE, CPT_DLY_RUN} cpt_dly_state_e;
    typedef struct packed {
        cpt_dly_state_e st;
        logic [6:0] pre;
        logic [7:0] cnt;
        logic ev;
    } cpt_dly_s;
    cpt_dly_s s_q, s_d;
    logic tick;

    // Division factors 1, 4, 32, 128 selected by the prescaler field
    function automatic logic presc_tick(input logic [1:0] sel, input logic [6:0] p);
        case (sel)
            2'h0: presc_tick = 1'b1;
            2'h1: presc_tick = (p[1:0] == 2'h3);
            2'h2: presc_tick = (p[4:0] == 5'h1F);
            default: presc_tick = (p == 7'h7F);
        endcase
    endfunction : presc_tick

    always_comb begin
        s_d = s_q;
        s_d.ev = 1'b0;
        tick = presc_tick(presc_i, s_q.pre);
        case (s_q.st)
            CPT_DLY_IDLE: begin
                s_d.pre = 7'h00;
                s_d.cnt = 8'h00;
                if (on_time_entry_interrupt_i) begin
                    if (!delayed_i || dly_val_i == 8'h00) begin
                        s_d.ev = 1'b1;
                    end else begin
                        s_d.st = CPT_DLY_RUN;
                    end
                end
            end
            CPT_DLY_RUN: begin
                s_d.pre = s_q.pre + 7'h01;
                if (tick) begin
                    s_d.cnt = s_q.cnt + 8'h01;
                    if (s_d.cnt == dly_val_i) begin
                        s_d.ev = 1'b1;
                        s_d.st = CPT_DLY_IDLE;
                    end
                end
            end
            default: s_d.st = CPT_DLY_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '{st: CPT_DLY_IDLE, pre: 7'h00, cnt: 8'h00, ev: 1'b0};
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign event_o = s_q.ev;
endmodule : cpt_delay

// ==== cpt_core_model.sv ====
/*
 * Timer core model for the far side: counter, phase, cycle end and core waves.
 * Assumes the bench steps it from the bus clock; run_i low freezes the counter.
 */
`timescale 1ns/10ps
module cpt_core_model (
    // Clock and control
    input wire logic clk_i,
    input wire logic run_i,
    // Timer core signals
    output logic [11:0] count_o,
    output logic [1:0] phase_o,
    output logic cycle_end_o,
    output logic [1:0] wave_o
);
    logic [1:0] div_q = 2'h0;
    logic [5:0] step_q = 6'h0;
    // Each value stands four cycles so the two-stage synchroniser always sees it
    always @(posedge clk_i) begin
        if (run_i) begin
            div_q <= div_q + 2'h1;
            if (div_q == 2'h3) begin
                step_q <= step_q + 6'h1;
            end
        end
    end
    // Both halves carry the step so captures exercise all twelve bits
    assign count_o = {step_q, step_q};
    assign phase_o = step_q[5:4];
    assign cycle_end_o = (step_q == 6'h3F);
    assign wave_o = {phase_o == 2'h3, phase_o == 2'h1};
endmodule : cpt_core_model

// ==== cpt_top_monitor.sv ====
/*
 * Checker for cpt_top: bus answer, strobe widths, held requests, input actions.
 * Assumes the bind below and ce_i held high by the bench.
 */
`timescale 1ns/10ps
module cpt_top_monitor (
    // Clock and resets
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    // Bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic ack_o,
    // Events and requests
    input wire logic event_a_i,
    input wire logic event_b_i,
    input wire logic input_act_a_o,
    input wire logic input_act_b_o,
    input wire logic ev_b_clear_o,
    input wire logic ev_a_set_o,
    input wire logic ev_b_set_o,
    input wire logic ev_prog_o,
    input wire logic irq_ovf_o,
    input wire logic irq_on_time_entry_interrupt_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || por_i);
    logic wr;
    // Requests may only fall within two cycles after a write; the request is registered from the next flag value, on the same edge as the flag
    assign wr = cyc_i && stb_i && we_i;
    property p_ack_resp; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("request not answered");
    property p_ack_once; ack_o |=> !ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held too long");
    property p_bclr; ev_b_clear_o |=> !ev_b_clear_o; endproperty
    a_bclr: assert property (p_bclr) else $error("b clear strobe too long");
    property p_aset; ev_a_set_o |=> !ev_a_set_o; endproperty
    a_aset: assert property (p_aset) else $error("a set strobe too long");
    property p_bset; ev_b_set_o |=> !ev_b_set_o; endproperty
    a_bset: assert property (p_bset) else $error("b set strobe too long");
    property p_prog; ev_prog_o |=> !ev_prog_o; endproperty
    a_prog: assert property (p_prog) else $error("programmable strobe too long");
    property p_ovf_hold; irq_ovf_o && !wr && !$past(wr) |=> irq_ovf_o; endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow request dropped");
    property p_on_time_entry_interrupt_hold; irq_on_time_entry_interrupt_o && !wr && !$past(wr) |=> irq_on_time_entry_interrupt_o; endproperty
    a_on_time_entry_interrupt_hold: assert property (p_on_time_entry_interrupt_hold) else $error("trigger request dropped");
    property p_act_a; input_act_a_o |-> $past(event_a_i, 3) ##1 !input_act_a_o; endproperty
    a_act_a: assert property (p_act_a) else $error("action A without event");
    property p_act_b; input_act_b_o |-> $past(event_b_i, 3) ##1 !input_act_b_o; endproperty
    a_act_b: assert property (p_act_b) else $error("action B without event");
endmodule : cpt_top_monitor

bind cpt_top cpt_top_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .ack_o(ack_o), .event_a_i(event_a_i), .event_b_i(event_b_i),
    .input_act_a_o(input_act_a_o), .input_act_b_o(input_act_b_o), .ev_b_clear_o(ev_b_clear_o),
    .ev_a_set_o(ev_a_set_o), .ev_b_set_o(ev_b_set_o), .ev_prog_o(ev_prog_o),
    .irq_ovf_o(irq_ovf_o), .irq_on_time_entry_interrupt_o(irq_on_time_entry_interrupt_o));

// ==== test_cpt_top.sv ====
/*
 * Directed testbench for cpt_top over classic Wishbone.
 * Assumes the core model on the timer side and one 250 MHz clock.
 */
`timescale 1ns/10ps
module test_cpt_top;
    import cpt_pkg::*;
    logic clk_i = 0, rst_i = 1, por_i = 1, ce_i = 1, run = 0, fault_i = 0, ramp = 0;
    logic cyc_i = 0, stb_i = 0, we_i = 0, event_a_i = 0, event_b_i = 0;
    logic [7:0] fuse_cfg_i = 8'hA6, adr_i = 8'h00, od = 8'hA5;
    logic [3:0] sel_i = 4'hF, woe;
    logic [31:0] dat_i = 32'h0, dat_o, rd_q;
    logic [11:0] count_i, cnt;
    logic [1:0] phase_i, core_wave_i;
    logic cycle_end_i, ack_o, act_a, act_b, wa, wbo, wc, wd, ebc, eas, ebs, epg, iov, itr;
    logic [7:0] dly [4] = '{8'h0A, 8'h1A, 8'h2A, 8'h09};
    int dif [4] = '{2, 8, 64, 0};
    int fails = 0, total_checks = 0, n_bc = 0, n_as = 0, n_bs = 0, n_act = 0;
    int c1, c3, b0, b1, b2;
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        n_bc <= n_bc + ebc;
        n_as <= n_as + eas;
        n_bs <= n_bs + ebs;
        n_act <= n_act + act_a + act_b;
    end
    cpt_core_model u_core (.clk_i(clk_i), .run_i(run), .count_o(count_i), .phase_o(phase_i),
        .cycle_end_o(cycle_end_i), .wave_o(core_wave_i));
    cpt_top DUT (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .ce_i(ce_i), .fuse_cfg_i(fuse_cfg_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .count_i(count_i), .phase_i(phase_i), .one_ramp_i(ramp),
        .cycle_end_i(cycle_end_i), .fault_i(fault_i), .core_wave_i(core_wave_i),
        .event_a_i(event_a_i), .event_b_i(event_b_i), .input_act_a_o(act_a),
        .input_act_b_o(act_b), .waveform_out_a_o(wa), .waveform_out_b_o(wbo),
        .waveform_out_c_o(wc), .waveform_out_d_o(wd), .waveform_oe_o(woe), .ev_b_clear_o(ebc),
        .ev_a_set_o(eas), .ev_b_set_o(ebs), .ev_prog_o(epg), .irq_ovf_o(iov), .irq_on_time_entry_interrupt_o(itr));
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    // Request held from just after an edge until ack is seen high at an edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) fails++;
        rd_q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string m);
        bus(1'b0, a, 32'h0);
        chk(rd_q, exp, m);
    endtask : rchk
    task automatic poll(input int b);
        int n;
        n = 0;
        rd_q = 32'h0;
        while (rd_q[b] !== 1'b1 && n < 100) begin
            bus(1'b0, ADDR_INT_FLAG, 32'h0);
            n++;
        end
    endtask : poll
    // Freezes the core right after it enters phase p
    task automatic go(input logic [1:0] p);
        run <= 1'b1;
        @(posedge clk_i);
        while (phase_i !== p) @(posedge clk_i);
        run <= 1'b0;
        tick(8);
    endtask : go
    task automatic evp(input logic [1:0] m);
        {event_b_i, event_a_i} <= m;
        tick(8);
        {event_b_i, event_a_i} <= 2'b00;
        tick(8);
    endtask : evp
    task automatic meas(output int c);
        int n;
        n = 0;
        c = 0;
        while (ebs !== 1'b1 && n < 600) begin
            @(posedge clk_i);
            n++;
        end
        while (epg !== 1'b1 && c < 600) begin
            @(posedge clk_i);
            c++;
        end
    endtask : meas
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    initial begin
        #200000;
        fails++;
        finish_test;
    end
    initial begin
        tick(12);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        tick(3);
        rchk(ADDR_FAULT_CTRL, 32'h0, "fault after power-on");
        bus(1'b1, ADDR_FAULT_CTRL, 32'h3C);
        rst_i <= 1'b1;
        tick(12);
        chk({wd, wc, wbo, wa}, 4'h6, "levels under reset");
        rst_i <= 1'b0;
        tick(3);
        rchk(ADDR_FAULT_CTRL, 32'hA6, "fault reload");
        chk(woe, 4'hA, "enables");
        bus(1'b1, 8'hFC, 32'hFF);
        rchk(8'hFC, 32'h0, "unmapped");
        bus(1'b1, ADDR_CTRL_D, od);
        for (int s = 0; s < 2; s++) begin
            bus(1'b1, ADDR_CTRL_C, s ? 32'h41 : 32'h81);
            for (int p = 0; p < 4; p++) begin
                go(p);
                chk({wd, wc, wbo, wa}, s ? {od[p], od[4+p], od[4+p], od[p]} :
                    {od[4+p], od[p], od[4+p], od[p]}, "override");
            end
        end
        // One ramp: A holds its on-A level through dead B
        ramp <= 1'b1;
        go(2);
        chk({wbo, wa}, {od[6], od[1]}, "one-ramp override");
        ramp <= 1'b0;
        bus(1'b1, ADDR_CTRL_C, 32'h0);
        bus(1'b1, ADDR_CMP_BCLR, 32'h208);
        bus(1'b1, ADDR_CMP_ASET, 32'h618);
        bus(1'b1, ADDR_CMP_BSET, 32'hA28);
        run <= 1'b1;
        tick(256);
        b0 = n_bc;
        b1 = n_as;
        b2 = n_bs;
        tick(512);
        chk(n_bc - b0, 2, "b clear events");
        chk(n_as - b1, 2, "a set events");
        chk(n_bs - b2, 2, "b set events");
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, ADDR_DLY_CTRL, dly[i]);
            bus(1'b1, ADDR_DLY_VAL, 32'h1);
            meas(c1);
            meas(c1);
            bus(1'b1, ADDR_DLY_VAL, 32'h3);
            meas(c3);
            meas(c3);
            chk(c3 - c1, dif[i], "event delay");
        end
        bus(1'b1, ADDR_DLY_CTRL, 32'h0);
        bus(1'b1, ADDR_INT_EN, 32'h1);
        go(3);
        bus(1'b1, ADDR_INT_FLAG, 32'h0D);
        go(1);
        chk(iov, 1, "overflow request");
        bus(1'b1, ADDR_INT_FLAG, 32'h0);
        tick(3);
        chk(iov, 1, "zero write kept flag");
        bus(1'b1, ADDR_INT_EN, 32'h0);
        tick(3);
        chk(iov, 0, "masked request");
        bus(1'b1, ADDR_INT_EN, 32'h0C);
        bus(1'b1, ADDR_INT_FLAG, 32'h1);
        go(2);
        bus(1'b1, ADDR_INT_FLAG, 32'h0D);
        go(3);
        chk(itr, 1, "trigger request");
        rchk(ADDR_INT_FLAG, 32'h08, "trigger flags");
        bus(1'b1, ADDR_INT_EN, 32'h0);
        bus(1'b1, ADDR_INT_FLAG, 32'h0D);
        bus(1'b1, ADDR_CTRL_E, 32'h04);
        poll(2);
        chk(rd_q[2], 1, "software capture flag");
        cnt = count_i;
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(rd_q[1], 0, "unit held");
        go(3);
        bus(1'b1, ADDR_INT_FLAG, 32'h0D);
        bus(1'b1, ADDR_CTRL_E, 32'h04);
        tick(20);
        rchk(ADDR_INT_FLAG, 32'h0, "busy strobe dropped");
        rchk(ADDR_SNAP_A_LO, cnt[7:0], "capture A low");
        rchk(ADDR_SNAP_A_HI, cnt[11:8], "capture A high");
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(rd_q[1], 1, "command ready");
        cnt = count_i;
        bus(1'b1, ADDR_CTRL_E, 32'h04);
        poll(2);
        rchk(ADDR_SNAP_A_LO, cnt[7:0], "recapture low");
        rchk(ADDR_SNAP_A_HI, cnt[11:8], "recapture high");
        bus(1'b1, ADDR_EVENT_INPUT_CONTROL_A, 32'h1);
        bus(1'b1, ADDR_EVENT_INPUT_CONTROL_B, 32'h1);
        bus(1'b1, ADDR_INT_FLAG, 32'h0D);
        c1 = n_act;
        evp(2'b11);
        chk(n_act - c1, 2, "input actions");
        rchk(ADDR_INT_FLAG, 32'h0, "no capture without action");
        bus(1'b1, ADDR_EVENT_INPUT_CONTROL_B, 32'h5);
        evp(2'b10);
        poll(3);
        chk(rd_q[3], 1, "event capture flag");
        rchk(ADDR_SNAP_B_LO, cnt[7:0], "capture B low");
        rchk(ADDR_SNAP_B_HI, cnt[11:8], "capture B high");
        // Fault values match override bits 0 and 2 of each selected source
        bus(1'b1, ADDR_FAULT_CTRL, 32'hF5);
        fault_i <= 1'b1;
        tick(8);
        chk({wd, wc, wbo, wa}, 4'h5, "fault levels");
        chk(woe, 4'hF, "fault enables");
        finish_test;
    end
endmodule : test_cpt_top
